//--- core/mmio_queue_defines.vh
// Register offsets and sizing constants for the queue bank.
`ifndef MMIO_QUEUE_DEFINES_VH
`define MMIO_QUEUE_DEFINES_VH
// =====================================================================
// Register offsets, byte addresses from the block base.
`define OFS_OFFERED_FEATURE_WORD_PICK 12'h014
`define OFS_ACCEPTED_FEATURE_BITS 12'h020
`define OFS_ACCEPTED_FEATURE_WORD_PICK 12'h024
`define OFS_DRIVER_PAGE_BYTES 12'h028
`define OFS_RING_INDEX_SELECT 12'h030
`define OFS_RING_SIZE_LIMIT 12'h034
`define OFS_RING_ENTRY_COUNT 12'h038
`define OFS_USED_RING_ALIGNMENT 12'h03c
`define OFS_RING_PAGE_FRAME 12'h040
`define OFS_RING_DOORBELL 12'h050
`define OFS_IRQ_PENDING_FLAGS 12'h060
`define OFS_IRQ_CLEAR_MASK 12'h064
`define OFS_DEVICE_STATUS 12'h070
// =====================================================================
// Queue count and index width.
`define RING_COUNT 4
`define RING_IDX_W 2
// Largest element count offered for every available queue.
`define RING_SIZE_MAX 32'h0000_0100
// Reset values.
`define RESET_WORD 32'h0000_0000
`define RESET_PAGE_BYTES 32'h0000_1000
`endif

//--- core/legacy_mmio_queue_regs.v
// Page-addressed queue control register bank with event status flags.
`timescale 1ns/1ps
`include "mmio_queue_defines.vh"

module legacy_mmio_queue_regs
(
    SYS_CLK,
    RST_B,
    REG_ADDR,
    REG_WR,
    REG_RD,
    REG_WDATA,
    REG_RDATA,
    RING_AVAILABLE,
    EVENT_SET,
    RING_SEL_OUT,
    RING_ACTIVE,
    RING_BASE_ADDR,
    RING_ENTRY_COUNT,
    RING_ALIGNMENT,
    OFFERED_WORD_PICK,
    ACCEPTED_WORD_PICK,
    ACCEPTED_BITS,
    DOORBELL_PULSE,
    DOORBELL_DATA,
    IRQ_PENDING,
    DEVICE_STATUS
);
    input wire SYS_CLK;
    input wire RST_B;
    input wire [11:0] REG_ADDR;
    input wire REG_WR;
    input wire REG_RD;
    input wire [31:0] REG_WDATA;
    output reg [31:0] REG_RDATA;
    input wire [`RING_COUNT-1:0] RING_AVAILABLE;
    input wire [31:0] EVENT_SET;
    output wire [`RING_IDX_W-1:0] RING_SEL_OUT;
    output wire [`RING_COUNT-1:0] RING_ACTIVE;
    output wire [63:0] RING_BASE_ADDR;
    output wire [31:0] RING_ENTRY_COUNT;
    output wire [31:0] RING_ALIGNMENT;
    output wire [31:0] OFFERED_WORD_PICK;
    output wire [31:0] ACCEPTED_WORD_PICK;
    output wire [31:0] ACCEPTED_BITS;
    output reg DOORBELL_PULSE;
    output reg [31:0] DOORBELL_DATA;
    output wire [31:0] IRQ_PENDING;
    output wire [31:0] DEVICE_STATUS;

    // =================================================================
    // Reset release through two flip-flops.
    reg rst_meta_ff;
    reg rst_sync_ff;
    always @(posedge SYS_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end
    wire rst_n = rst_sync_ff;

    // =================================================================
    // Write decode and shared state.
    reg [31:0] offered_pick_ff;
    reg [31:0] accepted_bits_ff;
    reg [31:0] accepted_pick_ff;
    reg [31:0] page_bytes_ff;
    reg [`RING_IDX_W-1:0] sel_ff;
    reg [31:0] pending_ff;
    reg [31:0] status_ff;
    reg [31:0] count_mem [0:`RING_COUNT-1];
    reg [31:0] align_mem [0:`RING_COUNT-1];
    reg [31:0] frame_mem [0:`RING_COUNT-1];

    // Address match is a function because reads and writes both use it.
    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    wire wr_status = REG_WR && hit(REG_ADDR, `OFS_DEVICE_STATUS);
    wire status_reset = wr_status && (REG_WDATA == `RESET_WORD);

    // Global registers; of these, a status reset clears only the status word and leaves the driver settings.
    always @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            offered_pick_ff <= `RESET_WORD;
            accepted_bits_ff <= `RESET_WORD;
            accepted_pick_ff <= `RESET_WORD;
            page_bytes_ff <= `RESET_PAGE_BYTES;
            sel_ff <= {`RING_IDX_W{1'b0}};
            status_ff <= `RESET_WORD;
        end
        else
        begin
            if (REG_WR && hit(REG_ADDR, `OFS_OFFERED_FEATURE_WORD_PICK))
                offered_pick_ff <= REG_WDATA;
            if (REG_WR && hit(REG_ADDR, `OFS_ACCEPTED_FEATURE_BITS))
                accepted_bits_ff <= REG_WDATA;
            if (REG_WR && hit(REG_ADDR, `OFS_ACCEPTED_FEATURE_WORD_PICK))
                accepted_pick_ff <= REG_WDATA;
            if (REG_WR && hit(REG_ADDR, `OFS_DRIVER_PAGE_BYTES))
                page_bytes_ff <= REG_WDATA;
            if (REG_WR && hit(REG_ADDR, `OFS_RING_INDEX_SELECT))
                sel_ff <= REG_WDATA[`RING_IDX_W-1:0];
            // Writing non-zero sets flags; zero clears them all.
            if (wr_status)
                status_ff <= status_reset ? `RESET_WORD :
                    (status_ff | REG_WDATA);
        end
    end

    // =================================================================
    // Per-queue storage; selection only steers which entry is touched.
    genvar g;
    generate
        for (g = 0; g < `RING_COUNT; g = g + 1)
        begin : ring_slot
            wire mine = (sel_ff == g);
            always @(posedge SYS_CLK or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    count_mem[g] <= `RESET_WORD;
                    align_mem[g] <= `RESET_WORD;
                    frame_mem[g] <= `RESET_WORD;
                end
                else
                begin
                    if (REG_WR && mine &&
                        hit(REG_ADDR, `OFS_RING_ENTRY_COUNT))
                        count_mem[g] <= REG_WDATA;
                    if (REG_WR && mine &&
                        hit(REG_ADDR, `OFS_USED_RING_ALIGNMENT))
                        align_mem[g] <= REG_WDATA;
                    // Device reset wins over a frame write to any queue.
                    if (status_reset)
                        frame_mem[g] <= `RESET_WORD;
                    else if (REG_WR && mine &&
                        hit(REG_ADDR, `OFS_RING_PAGE_FRAME))
                        frame_mem[g] <= REG_WDATA;
                end
            end
            // A zero frame is illegal, so it marks the queue inactive.
            assign RING_ACTIVE[g] = (frame_mem[g] != `RESET_WORD);
        end
    endgenerate

    // =================================================================
    // Event flags: set beats acknowledge in the same cycle.
    wire [31:0] ack_mask = (REG_WR && hit(REG_ADDR, `OFS_IRQ_CLEAR_MASK)) ?
        REG_WDATA : `RESET_WORD;
    always @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            pending_ff <= `RESET_WORD;
        else if (status_reset)
            pending_ff <= EVENT_SET;
        else
            pending_ff <= (pending_ff & ~ack_mask) | EVENT_SET;
    end

    // Doorbell write raises a one-cycle pulse with the written word.
    always @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            DOORBELL_PULSE <= 1'b0;
            DOORBELL_DATA <= `RESET_WORD;
        end
        else
        begin
            DOORBELL_PULSE <= REG_WR && hit(REG_ADDR, `OFS_RING_DOORBELL);
            if (REG_WR && hit(REG_ADDR, `OFS_RING_DOORBELL))
                DOORBELL_DATA <= REG_WDATA;
        end
    end

    // =================================================================
    // Read data is registered; write-only and unmapped offsets read zero.
    reg [31:0] nxt_rdata;
    always @*
    begin
        nxt_rdata = `RESET_WORD;
        if (hit(REG_ADDR, `OFS_RING_SIZE_LIMIT))
            nxt_rdata = RING_AVAILABLE[sel_ff] ?
                `RING_SIZE_MAX : `RESET_WORD;
        else if (hit(REG_ADDR, `OFS_RING_PAGE_FRAME))
            nxt_rdata = frame_mem[sel_ff];
        else if (hit(REG_ADDR, `OFS_IRQ_PENDING_FLAGS))
            nxt_rdata = pending_ff;
        else if (hit(REG_ADDR, `OFS_DEVICE_STATUS))
            nxt_rdata = status_ff;
    end

    always @(posedge SYS_CLK or negedge rst_n)
    begin
        if (!rst_n)
            REG_RDATA <= `RESET_WORD;
        else if (REG_RD)
            REG_RDATA <= nxt_rdata;
    end

    // =================================================================
    // Selected queue view for the ring engine.
    wire [63:0] frame_wide = {32'h0000_0000, frame_mem[sel_ff]};
    wire [63:0] page_wide = {32'h0000_0000, page_bytes_ff};
    wire [127:0] base_full = frame_wide * page_wide;
    // Truncation is safe: a 32-bit frame times a 32-bit size fits 64 bits.
    assign RING_BASE_ADDR = base_full[63:0];
    assign RING_SEL_OUT = sel_ff;
    assign RING_ENTRY_COUNT = count_mem[sel_ff];
    assign RING_ALIGNMENT = align_mem[sel_ff];
    assign OFFERED_WORD_PICK = offered_pick_ff;
    assign ACCEPTED_WORD_PICK = accepted_pick_ff;
    assign ACCEPTED_BITS = accepted_bits_ff;
    assign IRQ_PENDING = pending_ff;
    assign DEVICE_STATUS = status_ff;
endmodule // legacy_mmio_queue_regs

//--- test/legacy_mmio_queue_regs_sva.sv
// Port-level checks of the queue register bank.
`timescale 1ns/1ps
`include "mmio_queue_defines.vh"
// ====================================================
// Checker
module legacy_mmio_queue_regs_sva
(
    input wire SYS_CLK,
    input wire RST_B,
    input wire [11:0] REG_ADDR,
    input wire REG_WR,
    input wire REG_RD,
    input wire [31:0] REG_WDATA,
    input wire [31:0] REG_RDATA,
    input wire [`RING_COUNT-1:0] RING_AVAILABLE,
    input wire [31:0] EVENT_SET,
    input wire [`RING_IDX_W-1:0] RING_SEL_OUT,
    input wire [`RING_COUNT-1:0] RING_ACTIVE,
    input wire [63:0] RING_BASE_ADDR,
    input wire [31:0] RING_ENTRY_COUNT,
    input wire [31:0] IRQ_PENDING
);
    // One clock domain, so reset masks every check at once.
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);
    // Access steps that the properties start from.
    sequence s_wr(a); REG_WR && REG_ADDR == a; endsequence
    sequence s_rd(a); REG_RD && REG_ADDR == a; endsequence
    sequence s_rst; s_wr(12'h070) ##0 REG_WDATA == 32'h0; endsequence
    property p_sel;
        s_wr(12'h030) |=> RING_SEL_OUT == $past(REG_WDATA[1:0]);
    endproperty
    a_sel: assert property (p_sel) else $error("select not taken");
    property p_cnt;
        s_wr(12'h038) |=> RING_ENTRY_COUNT == $past(REG_WDATA);
    endproperty
    a_cnt: assert property (p_cnt) else $error("size not kept");
    property p_act;
        s_wr(12'h040) |=>
            RING_ACTIVE[$past(RING_SEL_OUT)] == ($past(REG_WDATA) != 32'h0);
    endproperty
    a_act: assert property (p_act) else $error("bad active");
    property p_base;
        !RING_ACTIVE[RING_SEL_OUT] |-> RING_BASE_ADDR == 64'h0;
    endproperty
    a_base: assert property (p_base) else $error("idle base");
    property p_lim;
        s_rd(12'h034) |-> ##1
            REG_RDATA == (RING_AVAILABLE[RING_SEL_OUT] ? `RING_SIZE_MAX : 32'h0);
    endproperty
    a_lim: assert property (p_lim) else $error("bad limit");
    property p_hold;
        !(REG_WR && (REG_ADDR == 12'h064 || REG_ADDR == 12'h070)) |=>
            (IRQ_PENDING & $past(IRQ_PENDING)) == $past(IRQ_PENDING);
    endproperty
    a_hold: assert property (p_hold) else $error("flag lost");
    property p_set;
        EVENT_SET != 32'h0 |=>
            (IRQ_PENDING & $past(EVENT_SET)) == $past(EVENT_SET);
    endproperty
    a_set: assert property (p_set) else $error("event lost");
    property p_ack;
        s_wr(12'h064) |=>
            (IRQ_PENDING & $past(REG_WDATA) & ~$past(EVENT_SET)) == 32'h0;
    endproperty
    a_ack: assert property (p_ack) else $error("ack ignored");
    property p_clr;
        s_rst |=> RING_ACTIVE == 4'h0;
    endproperty
    a_clr: assert property (p_clr) else $error("frames kept");
endmodule // legacy_mmio_queue_regs_sva

bind legacy_mmio_queue_regs legacy_mmio_queue_regs_sva chk_inst (
    .SYS_CLK(SYS_CLK), .RST_B(RST_B), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .RING_AVAILABLE(RING_AVAILABLE), .EVENT_SET(EVENT_SET),
    .RING_SEL_OUT(RING_SEL_OUT), .RING_ACTIVE(RING_ACTIVE),
    .RING_BASE_ADDR(RING_BASE_ADDR), .RING_ENTRY_COUNT(RING_ENTRY_COUNT),
    .IRQ_PENDING(IRQ_PENDING));

//--- test/legacy_mmio_queue_regs_tb_top.sv
// Self-checking bench for the queue register bank.
`timescale 1ns/1ps
`include "mmio_queue_defines.vh"
// ====================================================
// Bench top
module legacy_mmio_queue_regs_tb_top;
    reg sys_clk = 1'b0;
    reg rst_b = 1'b0;
    reg [11:0] addr = 12'h000;
    reg wr = 1'b0;
    reg rd = 1'b0;
    reg [31:0] wdata = 32'h0;
    reg [3:0] avail = 4'h5;
    reg [31:0] ev = 32'h0;
    reg [31:0] lim;
    wire [31:0] rdata, ecnt, align, opick, apick, abits, dbd;
    wire [3:0] act;
    wire bell;
    wire [31:0] dstat;
    wire [63:0] base;
    integer errors = 0;
    integer samples_checked = 0;
    integer q;
    // A 40 ns period gives the 25 MHz system clock.
    always #20 sys_clk = ~sys_clk;
    legacy_mmio_queue_regs legacy_mmio_queue_regs_inst (
        .SYS_CLK(sys_clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WR(wr),
        .REG_RD(rd), .REG_WDATA(wdata), .REG_RDATA(rdata),
        .RING_AVAILABLE(avail), .EVENT_SET(ev), .RING_SEL_OUT(),
        .RING_ACTIVE(act), .RING_BASE_ADDR(base), .RING_ENTRY_COUNT(ecnt),
        .RING_ALIGNMENT(align), .OFFERED_WORD_PICK(opick),
        .ACCEPTED_WORD_PICK(apick), .ACCEPTED_BITS(abits),
        .DOORBELL_PULSE(bell), .DOORBELL_DATA(dbd), .IRQ_PENDING(),
        .DEVICE_STATUS(dstat));
    // ====================================================
    // Tasks
    task chk(input [47:0] nm, input [63:0] e, input [63:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== e)
        begin
            errors = errors + 1;
            $display("[FAIL] %0s exp %h got %h", nm, e, got);
        end
    end
    endtask
    // Strobe stays up for exactly the taking edge.
    task reg_write(input [11:0] a, input [31:0] d);
    begin
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    end
    endtask
    // Read data is registered, so it is looked at half a cycle later.
    task reg_read(input [11:0] a, input [31:0] e);
    begin
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        chk("rdata", e, rdata);
    end
    endtask
    task end_of_test;
    begin
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    end
    endtask
    // ====================================================
    // Tests
    initial
    begin
        repeat (8) @(posedge sys_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reg_read(12'h040, 32'h0);
        reg_read(12'h0c0, 32'h0);
        reg_write(12'h028, 32'h2000);
        for (q = 0; q < 4; q = q + 1)
        begin
            lim = avail[q] ? `RING_SIZE_MAX : 32'h0;
            reg_write(12'h030, q);
            reg_read(12'h034, lim);
            reg_write(12'h038, 32'h10 + q);
            reg_write(12'h03c, 32'h100 << q);
            reg_write(12'h040, 32'h80 + q);
        end
        for (q = 3; q >= 0; q = q - 1)
        begin
            reg_write(12'h030, q);
            reg_read(12'h040, 32'h80 + q);
            chk("count", 32'h10 + q, ecnt);
            chk("align", 32'h100 << q, align);
            chk("base", (64'h80 + q) * 64'h2000, base);
        end
        chk("active", 32'hf, act);
        reg_write(12'h030, 32'h1);
        reg_write(12'h040, 32'h0);
        @(negedge sys_clk);
        chk("active", 32'hd, act);
        reg_read(12'h040, 32'h0);
        // Two events latch; one is acknowledged and the other stays set.
        @(posedge sys_clk);
        ev <= 32'h5;
        @(posedge sys_clk);
        ev <= 32'h0;
        reg_read(12'h060, 32'h5);
        reg_write(12'h064, 32'h1);
        reg_read(12'h060, 32'h4);
        // The doorbell pulse stands for one cycle only, so look at once.
        reg_write(12'h050, 32'h3);
        @(negedge sys_clk);
        chk("pulse", 64'h1, bell);
        reg_write(12'h014, 32'h1);
        reg_write(12'h020, 32'h9);
        reg_write(12'h024, 32'h2);
        @(negedge sys_clk);
        chk("pulse", 64'h0, bell);
        chk("bell", 32'h3, dbd);
        chk("opick", 32'h1, opick);
        chk("bits", 32'h9, abits);
        chk("apick", 32'h2, apick);
        // Non-zero status writes accumulate flags.
        reg_write(12'h070, 32'h3);
        reg_write(12'h070, 32'h4);
        reg_read(12'h070, 32'h7);
        chk("status", 64'h7, dstat);
        reg_write(12'h070, 32'h0);
        @(negedge sys_clk);
        chk("active", 32'h0, act);
        chk("status", 64'h0, dstat);
        reg_read(12'h060, 32'h0);
        end_of_test;
    end
    // The tests need about 4.2 us; a hang is cut off well after that.
    initial
    begin
        #100000;
        errors = errors + 1;
        end_of_test;
    end
endmodule // legacy_mmio_queue_regs_tb_top
